// ===== src/iwr_refresh.sv
// Range refresh engine with APB registers, unit tables and rack bus handshake
// How it works
// - Refresh every allocated word from first to last operand, both included.
// - Operands accepted only in words 0-999 or 2000-2959.
// - First above last sets the error flag, nothing is refreshed.
// - Range crossing basic and special areas is an error, no refresh.
// - Error flag cleared after a command with no error condition.
// - Special unit refreshed whole, only when its first word is in range.
// - High-density unit refreshed whole only when range starts at or before it.
// - Words with no mounted unit are skipped silently.
// - Units with I/O table error are skipped.
// - A rack bus fault aborts the remaining transfers.
// - Cyclic-enabled unit refreshed again after a refresh or direct access in the same scan raises duplicate error flag.
// - Cyclic-disabled unit not refreshed within 11 s of run gives monitor error.
`timescale 1ns/1ps
`default_nettype none
module iwr_refresh #(
    parameter logic [31:0] MONITOR_CYCLES = 32'(iwr_pkg::MONITOR_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scan_end,
    input wire logic unit_direct_read,
    input wire logic unit_direct_write,
    input wire logic [6:0] direct_unit,
    output logic xfer_req,
    output logic [11:0] xfer_addr,
    input wire logic xfer_ack,
    input wire logic bus_fault,
    output logic irq,
    output logic interrupt_task_error_flag,
    output logic host_error_indicator,
    output logic unit_run_indicator
);
    // Unit tables; presence bits live in reset flops so the walk never acts on an unloaded entry
    logic [7:0] basic_map [iwr_pkg::BASIC_WORDS];
    logic [7:0] unit_tab [iwr_pkg::SPEC_UNITS];
    logic [iwr_pkg::BASIC_WORDS-1:0] mount_reg;
    logic [iwr_pkg::SPEC_UNITS-1:0] present_reg;
    logic [iwr_pkg::SPEC_UNITS-1:0] need_reg;
    logic [iwr_pkg::SPEC_UNITS-1:0] scanned_reg;
    logic [iwr_pkg::SPEC_UNITS-1:0] accessed_reg;
    logic [iwr_pkg::SPEC_UNITS-1:0] seen_reg;

    logic [11:0] first_word_operand_reg;
    logic [11:0] last_word_operand_reg;
    logic run_reg;
    logic command_error_flag_reg;
    logic [4:0] irq_stat_reg;
    logic [4:0] irq_mask_reg;
    logic [15:0] xfer_cnt_reg;
    logic mon_fail_reg;
    iwr_pkg::iwr_eng_t state_reg;
    logic [11:0] word_reg;
    logic [6:0] unit_reg;
    logic [11:0] uw_reg;
    logic [11:0] burst_addr_reg;
    logic [5:0] burst_left_reg;
    logic in_spec_reg;

    // Rack bus inputs come from outside the clock domain
    logic ack_s;
    logic fault_s;
    logic expired;
    iwr_sync2 #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({bus_fault, xfer_ack}),
        .sync_out({fault_s, ack_s})
    );
    iwr_run_monitor #(.LIMIT(MONITOR_CYCLES)) u_mon (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_reg),
        .expired(expired)
    );

    // APB decode
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pready && pwrite;
    wire [1:0] win = paddr[13:12];
    wire [9:0] bidx = paddr[11:2];
    wire [6:0] uidx = paddr[8:2];
    wire basic_hit = (win == iwr_pkg::WIN_BASIC) && (bidx < 10'(iwr_pkg::BASIC_WORDS));
    wire unit_hit = (win == iwr_pkg::WIN_UNIT) && (paddr[11:9] == 3'h0) && (uidx < iwr_pkg::SPEC_UNITS_7);
    wire reg_ctrl = paddr == iwr_pkg::OFF_CTRL;
    wire reg_first = paddr == iwr_pkg::OFF_FIRST;
    wire reg_last = paddr == iwr_pkg::OFF_LAST;
    wire reg_stat = paddr == iwr_pkg::OFF_STATUS;
    wire reg_istat = paddr == iwr_pkg::OFF_IRQ_STAT;
    wire reg_imask = paddr == iwr_pkg::OFF_IRQ_MASK;
    wire reg_cnt = paddr == iwr_pkg::OFF_XFER_CNT;
    wire reg_hit = reg_ctrl | reg_first | reg_last | reg_stat | reg_istat | reg_imask | reg_cnt;
    wire mapped = reg_hit | basic_hit | unit_hit;
    wire busy = state_reg != iwr_pkg::ENG_IDLE;
    wire go = wr_acc && reg_ctrl && pwdata[iwr_pkg::CTRL_GO] && !busy;

    wire [31:0] status_val = {28'h0000000, irq_stat_reg[iwr_pkg::IRQ_DUP], mon_fail_reg,
                              command_error_flag_reg, busy};
    wire [31:0] basic_val = basic_hit ? {24'h000000, basic_map[bidx][7:1], mount_reg[bidx]} : 32'h00000000;
    wire [31:0] unit_val = unit_hit ? {24'h000000, unit_tab[uidx][7:1], present_reg[uidx]} : 32'h00000000;
    wire [31:0] rd_val =
        reg_ctrl ? {30'h00000000, run_reg, 1'b0} :
        reg_first ? {20'h00000, first_word_operand_reg} :
        reg_last ? {20'h00000, last_word_operand_reg} :
        reg_stat ? status_val :
        reg_istat ? {27'h0000000, irq_stat_reg} :
        reg_imask ? {27'h0000000, irq_mask_reg} :
        reg_cnt ? {16'h0000, xfer_cnt_reg} :
        (win == iwr_pkg::WIN_BASIC) ? basic_val : unit_val;

    // Answer is prepared in the setup cycle so every bus output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (setup && !pwrite && mapped) ? rd_val : 32'h00000000;
            pready <= setup;
            pslverr <= setup && !mapped;
        end
    end

    // Operand checks, done before the engine leaves CHECK
    wire [11:0] fw = first_word_operand_reg;
    wire [11:0] lw = last_word_operand_reg;
    wire f_basic = fw <= iwr_pkg::BASIC_LAST;
    wire l_basic = lw <= iwr_pkg::BASIC_LAST;
    wire f_spec = (fw >= iwr_pkg::SPEC_FIRST) && (fw <= iwr_pkg::SPEC_LAST);
    wire l_spec = (lw >= iwr_pkg::SPEC_FIRST) && (lw <= iwr_pkg::SPEC_LAST);
    wire range_ok = (f_basic && l_basic) || (f_spec && l_spec);
    wire order_ok = fw <= lw;
    wire cmd_bad = !(range_ok && order_ok);

    // Current table entries seen by the walk
    wire [7:0] bent = basic_map[word_reg[9:0]];
    wire bmount = (word_reg <= iwr_pkg::BASIC_LAST) && mount_reg[word_reg[9:0]];
    wire [7:0] uent = unit_tab[unit_reg];
    wire upres = present_reg[unit_reg];
    wire b_skip = !bmount || bent[iwr_pkg::BM_TBL_ERR] ||
                  (bent[iwr_pkg::BM_HD] && !bent[iwr_pkg::BM_HD_FIRST]);
    wire [5:0] b_len = bent[iwr_pkg::BM_HD] ? (6'(bent[7:iwr_pkg::BM_LEN_LSB]) + 6'h01) : 6'h01;
    wire [2:0] u_span = 3'(uent[4:iwr_pkg::UT_SPAN_LSB]) + 3'h1;
    wire [5:0] u_len = 6'(u_span * 4'ha);
    wire u_skip = (uw_reg < fw) || !upres || uent[iwr_pkg::UT_TBL_ERR];
    wire u_end = (unit_reg >= iwr_pkg::SPEC_UNITS_7) || (uw_reg > lw);
    wire u_take = (state_reg == iwr_pkg::ENG_SPEC) && !u_end && !u_skip;
    wire u_dup = u_take && !uent[iwr_pkg::UT_CYC_DIS] &&
                 (scanned_reg[unit_reg] || accessed_reg[unit_reg]);
    wire aborting = fault_s && ((state_reg == iwr_pkg::ENG_ACK) || (state_reg == iwr_pkg::ENG_REL));

    // Refresh engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= iwr_pkg::ENG_IDLE;
            word_reg <= 12'h000;
            unit_reg <= 7'h00;
            uw_reg <= 12'h000;
            burst_addr_reg <= 12'h000;
            burst_left_reg <= 6'h00;
            in_spec_reg <= 1'b0;
            xfer_req <= 1'b0;
            xfer_addr <= 12'h000;
            command_error_flag_reg <= 1'b0;
            xfer_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                iwr_pkg::ENG_IDLE: begin
                    if (go) begin
                        state_reg <= iwr_pkg::ENG_CHECK;
                        xfer_cnt_reg <= 16'h0000;
                    end
                end
                iwr_pkg::ENG_CHECK: begin
                    if (cmd_bad) begin
                        command_error_flag_reg <= 1'b1;
                        state_reg <= iwr_pkg::ENG_IDLE;
                    end else if (f_basic) begin
                        word_reg <= fw;
                        in_spec_reg <= 1'b0;
                        state_reg <= iwr_pkg::ENG_BASIC;
                    end else begin
                        unit_reg <= 7'h00;
                        uw_reg <= iwr_pkg::SPEC_FIRST;
                        in_spec_reg <= 1'b1;
                        state_reg <= iwr_pkg::ENG_SPEC;
                    end
                end
                iwr_pkg::ENG_BASIC: begin
                    if (word_reg > lw) begin
                        state_reg <= iwr_pkg::ENG_DONE;
                    end else if (b_skip) begin
                        word_reg <= word_reg + 12'h001;
                    end else begin
                        // Whole high-density block even past the last operand
                        burst_addr_reg <= word_reg;
                        burst_left_reg <= b_len;
                        word_reg <= word_reg + 12'(b_len);
                        state_reg <= iwr_pkg::ENG_REQ;
                    end
                end
                iwr_pkg::ENG_SPEC: begin
                    if (u_end) begin
                        state_reg <= iwr_pkg::ENG_DONE;
                    end else if (u_skip) begin
                        unit_reg <= unit_reg + 7'h01;
                        uw_reg <= uw_reg + iwr_pkg::WORDS_PER_UNIT;
                    end else begin
                        burst_addr_reg <= uw_reg;
                        burst_left_reg <= u_len;
                        unit_reg <= unit_reg + 7'(u_span);
                        uw_reg <= uw_reg + 12'(u_len);
                        state_reg <= iwr_pkg::ENG_REQ;
                    end
                end
                iwr_pkg::ENG_REQ: begin
                    xfer_req <= 1'b1;
                    xfer_addr <= burst_addr_reg;
                    state_reg <= iwr_pkg::ENG_ACK;
                end
                iwr_pkg::ENG_ACK: begin
                    if (aborting) begin
                        xfer_req <= 1'b0;
                        state_reg <= iwr_pkg::ENG_DONE;
                    end else if (ack_s) begin
                        xfer_req <= 1'b0;
                        xfer_cnt_reg <= xfer_cnt_reg + 16'h0001;
                        state_reg <= iwr_pkg::ENG_REL;
                    end
                end
                iwr_pkg::ENG_REL: begin
                    if (aborting) begin
                        state_reg <= iwr_pkg::ENG_DONE;
                    end else if (!ack_s) begin
                        burst_addr_reg <= burst_addr_reg + 12'h001;
                        burst_left_reg <= burst_left_reg - 6'h01;
                        if (burst_left_reg == 6'h01) begin
                            state_reg <= in_spec_reg ? iwr_pkg::ENG_SPEC : iwr_pkg::ENG_BASIC;
                        end else begin
                            state_reg <= iwr_pkg::ENG_REQ;
                        end
                    end
                end
                iwr_pkg::ENG_DONE: begin
                    command_error_flag_reg <= 1'b0;
                    state_reg <= iwr_pkg::ENG_IDLE;
                end
                default: begin
                    state_reg <= iwr_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // Tables: software loads them; a write during a refresh takes effect on the next entry read
    always_ff @(posedge pclk) begin
        if (wr_acc && basic_hit) begin
            basic_map[bidx] <= pwdata[7:0];
        end
        if (wr_acc && unit_hit) begin
            unit_tab[uidx] <= pwdata[7:0];
        end
    end

    wire direct_acc = unit_direct_read || unit_direct_write;
    wire run_rise = wr_acc && reg_ctrl && pwdata[iwr_pkg::CTRL_RUN] && !run_reg;
    genvar gu;
    generate
        for (gu = 0; gu < iwr_pkg::SPEC_UNITS; gu++) begin : g_unit
            wire hit = u_take && (unit_reg == 7'(gu));
            wire tw = wr_acc && unit_hit && (uidx == 7'(gu));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    present_reg[gu] <= 1'b0;
                    need_reg[gu] <= 1'b0;
                    scanned_reg[gu] <= 1'b0;
                    accessed_reg[gu] <= 1'b0;
                    seen_reg[gu] <= 1'b0;
                end else begin
                    if (tw) begin
                        present_reg[gu] <= pwdata[iwr_pkg::UT_PRESENT];
                        need_reg[gu] <= pwdata[iwr_pkg::UT_PRESENT] && pwdata[iwr_pkg::UT_CYC_DIS];
                    end
                    // A refresh or access in the clearing cycle still counts
                    scanned_reg[gu] <= hit || (scanned_reg[gu] && !scan_end);
                    accessed_reg[gu] <= (direct_acc && direct_unit == 7'(gu)) ||
                                        (accessed_reg[gu] && !scan_end);
                    seen_reg[gu] <= hit || (seen_reg[gu] && !run_rise);
                end
            end
        end
    endgenerate

    genvar gb;
    generate
        for (gb = 0; gb < iwr_pkg::BASIC_WORDS; gb++) begin : g_word
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mount_reg[gb] <= 1'b0;
                end else if (wr_acc && basic_hit && bidx == 10'(gb)) begin
                    mount_reg[gb] <= pwdata[iwr_pkg::BM_MOUNTED];
                end
            end
        end
    endgenerate

    // Monitor error latches until run is dropped
    wire mon_now = expired && |(need_reg & ~seen_reg);
    wire [4:0] events;
    assign events[iwr_pkg::IRQ_DONE] = (state_reg == iwr_pkg::ENG_DONE) ||
                                       ((state_reg == iwr_pkg::ENG_CHECK) && cmd_bad);
    assign events[iwr_pkg::IRQ_CMD_ERR] = (state_reg == iwr_pkg::ENG_CHECK) && cmd_bad;
    assign events[iwr_pkg::IRQ_BUS_FAULT] = aborting;
    assign events[iwr_pkg::IRQ_DUP] = u_dup;
    assign events[iwr_pkg::IRQ_MON] = mon_now && !mon_fail_reg;
    wire [4:0] w1c = (wr_acc && reg_istat) ? pwdata[4:0] : 5'h00;
    wire [4:0] stat_next = (irq_stat_reg & ~w1c) | events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_word_operand_reg <= 12'h000;
            last_word_operand_reg <= 12'h000;
            run_reg <= 1'b0;
            irq_mask_reg <= iwr_pkg::IRQ_MASK_RST;
            irq_stat_reg <= 5'h00;
            irq <= 1'b0;
            interrupt_task_error_flag <= 1'b0;
            mon_fail_reg <= 1'b0;
            host_error_indicator <= 1'b0;
            unit_run_indicator <= 1'b0;
        end else begin
            // Operands are frozen while a command runs
            if (wr_acc && reg_first && !busy) begin
                first_word_operand_reg <= pwdata[11:0];
            end
            if (wr_acc && reg_last && !busy) begin
                last_word_operand_reg <= pwdata[11:0];
            end
            if (wr_acc && reg_ctrl) begin
                run_reg <= pwdata[iwr_pkg::CTRL_RUN];
            end
            if (wr_acc && reg_imask) begin
                irq_mask_reg <= pwdata[4:0];
            end
            irq_stat_reg <= stat_next;
            irq <= |(stat_next & irq_mask_reg);
            interrupt_task_error_flag <= stat_next[iwr_pkg::IRQ_DUP];
            mon_fail_reg <= run_reg && (mon_fail_reg || mon_now);
            host_error_indicator <= run_reg && (mon_fail_reg || mon_now);
            unit_run_indicator <= run_reg && (mon_fail_reg || mon_now);
        end
    end
endmodule
`default_nettype wire

// ===== pkg/iwr_pkg.sv
// Constants shared by the I/O word range refresh engine
package iwr_pkg;
    // APB register offsets (byte addresses)
    localparam logic [13:0] OFF_CTRL = 14'h0000;
    localparam logic [13:0] OFF_FIRST = 14'h0004;
    localparam logic [13:0] OFF_LAST = 14'h0008;
    localparam logic [13:0] OFF_STATUS = 14'h000c;
    localparam logic [13:0] OFF_IRQ_STAT = 14'h0010;
    localparam logic [13:0] OFF_IRQ_MASK = 14'h0014;
    localparam logic [13:0] OFF_XFER_CNT = 14'h0018;
    // Table windows, one entry per aligned word
    localparam logic [1:0] WIN_REGS = 2'h0;
    localparam logic [1:0] WIN_BASIC = 2'h1;
    localparam logic [1:0] WIN_UNIT = 2'h2;
    // CTRL bits
    localparam int CTRL_GO = 0;
    localparam int CTRL_RUN = 1;
    // STATUS bits
    localparam int ST_BUSY = 0;
    localparam int ST_CMD_ERR = 1;
    localparam int ST_MON_ERR = 2;
    localparam int ST_ITEF = 3;
    // IRQ status / mask bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CMD_ERR = 1;
    localparam int IRQ_BUS_FAULT = 2;
    localparam int IRQ_DUP = 3;
    localparam int IRQ_MON = 4;
    localparam int IRQ_W = 5;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;
    // Basic word map entry fields
    localparam int BM_MOUNTED = 0;
    localparam int BM_TBL_ERR = 1;
    localparam int BM_HD = 2;
    localparam int BM_HD_FIRST = 3;
    localparam int BM_LEN_LSB = 4;
    // Special unit table entry fields
    localparam int UT_PRESENT = 0;
    localparam int UT_TBL_ERR = 1;
    localparam int UT_CYC_DIS = 2;
    localparam int UT_SPAN_LSB = 3;
    // Word areas
    localparam logic [11:0] BASIC_LAST = 12'h3e7;
    localparam logic [11:0] SPEC_FIRST = 12'h7d0;
    localparam logic [11:0] SPEC_LAST = 12'hb8f;
    localparam int BASIC_WORDS = 1000;
    localparam int SPEC_UNITS = 96;
    localparam logic [6:0] SPEC_UNITS_7 = 7'h60;
    localparam logic [11:0] WORDS_PER_UNIT = 12'h00a;
    // Start-of-run monitor window
    localparam longint unsigned MONITOR_TIME_S = 11;
    localparam longint unsigned CLK_HZ = 200_000_000;
    localparam longint unsigned MONITOR_CYCLES = MONITOR_TIME_S * CLK_HZ;
    typedef enum logic [2:0] {
        ENG_IDLE, ENG_CHECK, ENG_BASIC, ENG_SPEC, ENG_REQ, ENG_ACK, ENG_REL, ENG_DONE
    } iwr_eng_t;
endpackage

// ===== src/iwr_sync2.sv
// Two-flop synchroniser for rack bus inputs
`timescale 1ns/1ps
`default_nettype none
module iwr_sync2 #(
    parameter int W = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== src/iwr_run_monitor.sv
// Start-of-run window timer for units with cyclic refresh disabled
`timescale 1ns/1ps
`default_nettype none
module iwr_run_monitor #(
    parameter logic [31:0] LIMIT = 32'h00000010
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic expired
);
    logic [31:0] cnt_reg;
    wire at_limit = (cnt_reg >= LIMIT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h00000000;
            expired <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 32'h00000000;
            expired <= 1'b0;
        end else if (!at_limit) begin
            cnt_reg <= cnt_reg + 32'h00000001;
        end else begin
            expired <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/iwr_refresh_sva.sv
// Port-level checker for the range refresh engine
`timescale 1ns/1ps
`default_nettype none
module iwr_refresh_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic xfer_req,
    input wire logic [11:0] xfer_addr,
    input wire logic xfer_ack,
    input wire logic bus_fault,
    input wire logic host_error_indicator,
    input wire logic unit_run_indicator
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_apb_ready: assert property (psel && !penable |=> pready) else $error("late ready");
    a_err_ready: assert property (pslverr |-> pready && penable) else $error("stray slave error");
    a_addr_area: assert property (xfer_req |-> xfer_addr <= 12'hb8f &&
        (xfer_addr <= 12'h3e7 || xfer_addr >= 12'h7d0)) else $error("word outside areas");
    a_addr_hold: assert property (xfer_req && $past(xfer_req) |-> $stable(xfer_addr))
        else $error("word address moved");
    a_req_hold: assert property ($rose(xfer_req) |=> xfer_req) else $error("short request");
    a_req_ack: assert property ($fell(xfer_req) |-> $past(xfer_ack, 2) || $past(bus_fault, 2))
        else $error("request dropped early");
    a_req_gap: assert property ($fell(xfer_req) |-> !xfer_req [*3]) else $error("request too soon");
    a_ind_pair: assert property (host_error_indicator == unit_run_indicator)
        else $error("indicators split");
    c_xfer: cover property ($fell(xfer_req));
    c_slverr: cover property (pslverr);
    c_mon: cover property ($rose(host_error_indicator));
endmodule
bind iwr_refresh iwr_refresh_sva u_iwr_refresh_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .xfer_req, .xfer_addr, .xfer_ack, .bus_fault, .host_error_indicator, .unit_run_indicator);
`default_nettype wire

// ===== bench/iwr_rack_model.sv
// Behavioural rack bus that acknowledges word transfers, may stall or fault
`timescale 1ns/1ps
`default_nettype none
module iwr_rack_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic xfer_req,
    input wire logic [11:0] xfer_addr,
    input wire logic slow,
    input wire logic [31:0] fault_at,
    output logic xfer_ack,
    output logic bus_fault
);
    logic [11:0] seen [$];
    int dly;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_ack <= 1'b0;
            bus_fault <= 1'b0;
            dly <= 0;
        end else begin
            // Fault held only while the request stands, so an abort releases it
            bus_fault <= xfer_req && fault_at == 32'(seen.size());
            if (!xfer_req) begin
                xfer_ack <= 1'b0;
            end else if (!xfer_ack && fault_at != 32'(seen.size())) begin
                dly <= dly + 1;
                if (dly >= (slow ? 6 : 0)) begin
                    xfer_ack <= 1'b1;
                    seen.push_back(xfer_addr);
                    dly <= 0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the range refresh engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, scan_end = 0, drd = 0, dwr = 0, slow = 0;
    logic pready, pslverr, xfer_req, xfer_ack, bus_fault, irq, itef, herr, urun, e, run = 0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0, fault_at = 32'hffffffff, prdata, q;
    logic [6:0] dunit = 7'h01;
    logic [11:0] xfer_addr;
    logic [21:0] tbl [9] = '{22'h101401, 22'h101801, 22'h101c01, 22'h102003, 22'h10502d,
        22'h105425, 22'h105825, 22'h200005, 22'h200409};
    logic [55:0] ok_cmd [5] = '{56'h7d07d00a7d07d9, 56'h00501506005016, 56'h01501600000000,
        56'h7df7f300000000, 56'h7d57dc147da7ed};
    logic [23:0] bad [4] = '{24'h00a005, 24'h3de7d0, 24'h3e83e8, 24'hb90b90};
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    // Short monitor window keeps the run brief
    iwr_refresh #(.MONITOR_CYCLES(32'h000000c8)) u_iwr_refresh (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .scan_end, .unit_direct_read(drd), .unit_direct_write(dwr),
        .direct_unit(dunit), .xfer_req, .xfer_addr, .xfer_ack, .bus_fault, .irq,
        .interrupt_task_error_flag(itef), .host_error_indicator(herr), .unit_run_indicator(urun));
    iwr_rack_model u_iwr_rack_model (.pclk, .presetn, .xfer_req, .xfer_addr, .slow, .fault_at, .xfer_ack,
        .bus_fault);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [11:0] f, input logic [11:0] l);
        u_iwr_rack_model.seen.delete();
        apb(1'b1, iwr_pkg::OFF_FIRST, 32'(f));
        apb(1'b1, iwr_pkg::OFF_LAST, 32'(l));
        apb(1'b1, iwr_pkg::OFF_CTRL, {30'h0, run, 1'b1});
        do apb(1'b0, iwr_pkg::OFF_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic seen_is(input logic [7:0] n, input logic [11:0] lo, input logic [11:0] hi);
        chk(32'(u_iwr_rack_model.seen.size()), 32'(n));
        if (n > 0) chk({8'h0, u_iwr_rack_model.seen[0], u_iwr_rack_model.seen[$]}, {8'h0, lo, hi});
    endtask
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, iwr_pkg::OFF_IRQ_MASK, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 14'h0ffc, 32'h0);
        chk({31'h0, e}, 32'h1);
        foreach (tbl[i]) apb(1'b1, tbl[i][21:8], {24'h0, tbl[i][7:0]});
        run = 1'b1;
        foreach (ok_cmd[i]) begin
            cmd(ok_cmd[i][55:44], ok_cmd[i][43:32]);
            chk({31'h0, q[1]}, 32'h0);
            seen_is(ok_cmd[i][31:24], ok_cmd[i][23:12], ok_cmd[i][11:0]);
        end
        chk({31'h0, herr}, 32'h0);
        chk({31'h0, itef}, 32'h0);
        apb(1'b0, iwr_pkg::OFF_XFER_CNT, 32'h0);
        chk(q, 32'h14);
        cmd(12'h7da, 12'h7da);
        chk({31'h0, itef}, 32'h1);
        apb(1'b1, iwr_pkg::OFF_IRQ_STAT, 32'h1f);
        @(posedge pclk);
        scan_end <= 1'b1;
        @(posedge pclk);
        scan_end <= 1'b0;
        cmd(12'h7da, 12'h7da);
        chk({31'h0, itef}, 32'h0);
        @(posedge pclk);
        // Scan flags cleared with the access, so only the access can flag a duplicate
        {scan_end, drd} <= 2'h3;
        @(posedge pclk);
        {scan_end, drd} <= 2'h0;
        cmd(12'h7da, 12'h7da);
        chk({31'h0, itef}, 32'h1);
        apb(1'b1, iwr_pkg::OFF_IRQ_STAT, 32'h1f);
        @(posedge pclk);
        {scan_end, dwr} <= 2'h3;
        @(posedge pclk);
        {scan_end, dwr} <= 2'h0;
        cmd(12'h7da, 12'h7da);
        chk({31'h0, itef}, 32'h1);
        foreach (bad[i]) begin
            cmd(bad[i][23:12], bad[i][11:0]);
            chk({31'h0, q[1]}, 32'h1);
            seen_is(8'h0, 12'h0, 12'h0);
        end
        cmd(12'h005, 12'h005);
        chk({31'h0, q[1]}, 32'h0);
        apb(1'b1, iwr_pkg::OFF_IRQ_STAT, 32'h1f);
        apb(1'b1, iwr_pkg::OFF_IRQ_MASK, 32'h4);
        fault_at <= 32'h2;
        slow <= 1'b1;
        cmd(12'h005, 12'h007);
        seen_is(8'h2, 12'h005, 12'h006);
        fault_at <= 32'hffffffff;
        slow <= 1'b0;
        apb(1'b0, iwr_pkg::OFF_IRQ_STAT, 32'h0);
        chk(q & 32'h4, 32'h4);
        irq_is(1'b1);
        apb(1'b1, iwr_pkg::OFF_IRQ_MASK, 32'h0);
        irq_is(1'b0);
        apb(1'b1, iwr_pkg::OFF_IRQ_MASK, 32'h4);
        irq_is(1'b1);
        apb(1'b1, iwr_pkg::OFF_IRQ_STAT, 32'h4);
        irq_is(1'b0);
        apb(1'b1, iwr_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, iwr_pkg::OFF_CTRL, 32'h2);
        repeat (250) @(posedge pclk);
        chk({30'h0, herr, urun}, 32'h3);
        report_and_stop();
    end
endmodule
`default_nettype wire
